// ---- logic/swl_params.svh ----
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

// register map of the plain register port
`define SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL       4'h0
`define SWL_ADDR_STATUS     4'h1
`define SWL_ADDR_PORT_A_WAKE_ENABLE       4'h2
`define SWL_ADDR_IRQ_FLAGS  4'h3
`define SWL_ADDR_IRQ_EN     4'h4
`define SWL_ADDR_CONFIG     4'h5

// low-voltage control register fields
`define SWL_LOW_VOLTAGE_DETECT_CONTROL_SEL_LSB    0
`define SWL_LOW_VOLTAGE_DETECT_CONTROL_EN_BIT     4
`define SWL_LOW_VOLTAGE_DETECT_CONTROL_OUT_BIT    5
`define SWL_LOW_VOLTAGE_DETECT_CONTROL_RESET      8'h00

// status register fields
`define SWL_STAT_PDF_BIT    0
`define SWL_STAT_TO_BIT     1
`define SWL_STAT_SLEEP_BIT  2

// config register fields
`define SWL_CFG_WDT_EN_BIT  0
`define SWL_CFG_WDT_SUB_BIT 1

// low-voltage interrupt delay, in ns, and derived cycle count
`define SWL_CLK_NS          25
`define SWL_LVD_DELAY_NS    120000
`define SWL_LVD_DELAY_CYC   ((`SWL_LVD_DELAY_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS)

`endif

// ---- logic/swl_pkg.sv ----
package swl_pkg;
    typedef enum logic [1:0] {
        SWL_RUN,
        SWL_SLEEP,
        SWL_WAKE
    } swl_state_t;

    typedef enum logic [1:0] {
        SWL_WAKE_NONE,
        SWL_WAKE_PORT,
        SWL_WAKE_IRQ,
        SWL_WAKE_WDT
    } swl_wake_t;

    // core events, one-cycle pulses; service_grp is the group number that goes with service_mf
    typedef struct packed {
        logic halt;
        logic clr_wdt;
        logic service_mf;
        logic [2:0] service_grp;
        logic ret_enable;
        logic ret_plain;
    } swl_core_ev_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } swl_reg_req_t;
endpackage

// ---- logic/swl_sleep_ctrl.sv ----
`include "swl_params.svh"
`timescale 1ns/10ps
`default_nettype none

module swl_sleep_ctrl #(
    parameter int unsigned LVD_DELAY_CYC = `SWL_LVD_DELAY_CYC
) (
    input  wire logic                 core_clk,      // system clock, 40 MHz
    input  wire logic                 reset_n,       // async power-on reset
    input  wire swl_pkg::swl_reg_req_t reg_req,      // register port request
    output logic [7:0]                reg_rdata,     // read data, cycle after rd
    input  wire swl_pkg::swl_core_ev_t core_ev,      // core instruction events
    input  wire logic                 stack_full,    // core stack has no free level
    input  wire logic [5:0]           src_irq_set,   // source flag set pulses
    input  wire logic                 ext_reset_n,   // external reset pin
    input  wire logic [7:0]           port_a_pin,    // port A pin levels
    input  wire logic                 wdt_overflow,  // watchdog overflow pulse
    input  wire logic                 lvd_comp,      // async comparator, 1 = low
    output logic [2:0]                threshold_select, // detector level code
    output logic                      detector_enable,  // detector power
    output logic                      sys_clk_en,    // system clock gate
    output logic                      wdt_run,       // watchdog counts
    output logic                      wdt_clear,     // watchdog clear pulse
    output logic                      core_reset,    // full system reset pulse
    output logic                      pc_sp_reset,   // watchdog reset pulse
    output logic                      irq_take,      // vector to service now
    output logic                      global_irq_enable // global enable
);
    import swl_pkg::*;

    // ======================================================
    // synchronisers
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_s3;
    logic [1:0] xr_s;
    logic       lvd_s1;
    logic       low_voltage_output;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pa_s1 <= 8'hFF;
            pa_s2 <= 8'hFF;
            pa_s3 <= 8'hFF;
            xr_s <= 2'h3;
            lvd_s1 <= 1'b0;
            low_voltage_output <= 1'b0;
        end else begin
            pa_s1 <= port_a_pin;
            pa_s2 <= pa_s1;
            pa_s3 <= pa_s2;
            xr_s <= {xr_s[0], ext_reset_n};
            // raw comparator level only meets the first stage; gating comes after it
            lvd_s1 <= lvd_comp;
            low_voltage_output <= lvd_s1 & detector_enable;
        end
    end

    // ======================================================
    // registers
    logic [7:0] port_a_wake_enable;
    logic [5:0] group_irq_request_flags;
    logic [5:0] irq_enable;
    logic       low_voltage_irq_flag;
    logic       power_down_flag;
    logic       watchdog_timeout_flag;
    logic [1:0] wdt_cfg;
    swl_state_t state;
    swl_wake_t  wake_src;
    logic [5:0] flags_at_halt;
    logic       ext_rst_q;

    wire wr_low_voltage_detect_control  = reg_req.wr && reg_req.addr == `SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL;
    wire wr_port_a_wake_enable  = reg_req.wr && reg_req.addr == `SWL_ADDR_PORT_A_WAKE_ENABLE;
    wire wr_flags = reg_req.wr && reg_req.addr == `SWL_ADDR_IRQ_FLAGS;
    wire wr_en    = reg_req.wr && reg_req.addr == `SWL_ADDR_IRQ_EN;
    wire wr_cfg   = reg_req.wr && reg_req.addr == `SWL_ADDR_CONFIG;
    wire asleep   = state == SWL_SLEEP;
    wire ext_rst  = ~xr_s[1];

    // ======================================================
    // low-voltage interrupt delay
    localparam int CW = $clog2(LVD_DELAY_CYC + 1);
    logic [CW-1:0] lvd_cnt;
    wire lvd_fire = low_voltage_output && lvd_cnt == CW'(LVD_DELAY_CYC - 1);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            lvd_cnt <= '0;
        else if (!low_voltage_output)
            lvd_cnt <= '0;
        else if (lvd_cnt != CW'(LVD_DELAY_CYC))
            lvd_cnt <= lvd_cnt + CW'(1);
    end

    // source flag 7 is the low-voltage flag; its set also feeds group 0
    wire [5:0] set_vec = src_irq_set | {5'h0, lvd_fire};
    wire [5:0] clr_vec = core_ev.service_mf ? 6'(1) << core_ev.service_grp : 6'h0;
    // a software write also counts as a change, so a flag written high while asleep wakes too
    wire [5:0] next_flags = wr_flags ? (reg_req.wdata[5:0] | set_vec) :
                            ((group_irq_request_flags & ~clr_vec) | set_vec);

    // ======================================================
    // state machine and flags
    wire [5:0] rise_vec = next_flags & ~flags_at_halt;
    wire       irq_wake = |rise_vec;
    wire       pa_fall  = |(pa_s3 & ~pa_s2 & port_a_wake_enable);
    wire       wdt_wake = wdt_overflow && wdt_cfg[`SWL_CFG_WDT_EN_BIT];
    wire       pending  = |(group_irq_request_flags & irq_enable);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SWL_RUN;
            wake_src <= SWL_WAKE_NONE;
            flags_at_halt <= 6'h0;
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            ext_rst_q <= 1'b0;
        end else begin
            ext_rst_q <= ext_rst;
            if (core_ev.clr_wdt)
                power_down_flag <= 1'b0;
            if (wdt_wake)
                watchdog_timeout_flag <= 1'b1;
            if (ext_rst) begin
                state <= SWL_RUN;
                power_down_flag <= 1'b0;
                watchdog_timeout_flag <= 1'b0;
            end else begin
                unique case (state)
                    SWL_RUN: begin
                        if (core_ev.halt) begin
                            state <= SWL_SLEEP;
                            flags_at_halt <= group_irq_request_flags;
                            power_down_flag <= 1'b1;
                            watchdog_timeout_flag <= 1'b0;
                        end
                    end
                    SWL_SLEEP: begin
                        flags_at_halt <= flags_at_halt & next_flags;
                        if (wdt_wake || pa_fall || irq_wake) begin
                            state <= SWL_WAKE;
                            wake_src <= wdt_wake ? SWL_WAKE_WDT :
                                        pa_fall ? SWL_WAKE_PORT : SWL_WAKE_IRQ;
                        end
                    end
                    SWL_WAKE: begin
                        state <= SWL_RUN;
                        wake_src <= SWL_WAKE_NONE;
                    end
                    default: state <= SWL_RUN;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            group_irq_request_flags <= 6'h0;
            low_voltage_irq_flag <= 1'b0;
            irq_enable <= 6'h0;
            port_a_wake_enable <= 8'h00;
            threshold_select <= 3'h0;
            detector_enable <= 1'b0;
            wdt_cfg <= 2'h0;
            global_irq_enable <= 1'b0;
        end else begin
            // hardware set wins over software clear
            group_irq_request_flags <= next_flags;
            if (lvd_fire)
                low_voltage_irq_flag <= 1'b1;
            else if (wr_flags && !reg_req.wdata[7])
                low_voltage_irq_flag <= 1'b0;
            if (wr_en)
                irq_enable <= reg_req.wdata[5:0];
            if (wr_port_a_wake_enable)
                port_a_wake_enable <= reg_req.wdata;
            if (wr_low_voltage_detect_control) begin
                threshold_select <= reg_req.wdata[`SWL_LOW_VOLTAGE_DETECT_CONTROL_SEL_LSB +: 3];
                detector_enable <= reg_req.wdata[`SWL_LOW_VOLTAGE_DETECT_CONTROL_EN_BIT];
            end
            if (wr_cfg)
                wdt_cfg <= reg_req.wdata[1:0];
            if (core_ev.service_mf || irq_take)
                global_irq_enable <= 1'b0;
            else if (core_ev.ret_enable)
                global_irq_enable <= 1'b1;
            else if (wr_cfg)
                global_irq_enable <= reg_req.wdata[7];
        end
    end

    // ======================================================
    // core-facing outputs
    assign sys_clk_en  = !asleep;
    assign wdt_run     = wdt_cfg[`SWL_CFG_WDT_EN_BIT] &&
                         (!asleep || wdt_cfg[`SWL_CFG_WDT_SUB_BIT]);
    assign wdt_clear   = core_ev.halt && state == SWL_RUN;
    assign core_reset  = ext_rst & ~ext_rst_q;
    assign pc_sp_reset = state == SWL_WAKE && wake_src == SWL_WAKE_WDT;
    // after a wake the core resumes after halt unless it can service now
    assign irq_take    = state == SWL_RUN && global_irq_enable && pending && !stack_full;

    // ======================================================
    // read port
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_req.addr)
            `SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL:
                rd_mux = {2'b00, low_voltage_output, detector_enable, 1'b0, threshold_select};
            `SWL_ADDR_STATUS:
                rd_mux = {5'h0, asleep, watchdog_timeout_flag, power_down_flag};
            `SWL_ADDR_PORT_A_WAKE_ENABLE:      rd_mux = port_a_wake_enable;
            `SWL_ADDR_IRQ_FLAGS: rd_mux = {low_voltage_irq_flag, 1'b0, group_irq_request_flags};
            `SWL_ADDR_IRQ_EN:    rd_mux = {2'b00, irq_enable};
            `SWL_ADDR_CONFIG:    rd_mux = {global_irq_enable, 5'h0, wdt_cfg};
            default:             rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
    end

    // ======================================================
    // checks
    AST_HALT_SETS_PDF: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.halt && state == SWL_RUN && !ext_rst) |=> power_down_flag && !watchdog_timeout_flag && asleep)
        else $error("halt did not set power-down");

    AST_CLK_STOPPED: assert property (@(posedge core_clk) disable iff (!reset_n)
        asleep |-> !sys_clk_en)
        else $error("clock runs while asleep");

    AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
        (group_irq_request_flags[1] && !core_ev.service_mf && !wr_flags) |=> group_irq_request_flags[1])
        else $error("irq flag lost");

    AST_RETURN_ENABLE_INSTR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.ret_enable && !core_ev.service_mf && !irq_take) |=> global_irq_enable)
        else $error("return-enable did not set enable");

    AST_IRQ_WAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && !ext_rst && src_irq_set[2] && !flags_at_halt[2]) |=> state == SWL_WAKE)
        else $error("irq rise did not wake");

    AST_NO_WAKE_HIGH: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && !ext_rst && !wdt_wake && !pa_fall && !wr_flags && set_vec == 6'h0) |=> !(state == SWL_WAKE))
        else $error("spurious wake");

    AST_LVD_DELAY: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(low_voltage_output) |-> !lvd_fire [*3])
        else $error("low-voltage flag too early");

    AST_WDT_RESET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && wdt_wake && !ext_rst) |=> pc_sp_reset && watchdog_timeout_flag)
        else $error("watchdog wake lost time-out");

    AST_LOW_VOLTAGE_DETECT_CONTROL_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reg_req.rd && reg_req.addr == `SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL) |-> reg_rdata[7:6] == 2'b00 && !reg_rdata[3])
        else $error("unimplemented bits nonzero");

    // plain return must never raise the global enable on its own
    AST_PLAIN_RET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.ret_plain && !core_ev.ret_enable && !wr_cfg && !global_irq_enable) |=> !global_irq_enable)
        else $error("plain return raised enable");

    AST_GROUP_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.service_mf && core_ev.service_grp == 3'h2 && !set_vec[2] && !wr_flags)
        |=> !group_irq_request_flags[2])
        else $error("serviced group flag kept");

    // the individual source flag is software's to clear
    AST_SOURCE_KEPT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.service_mf && low_voltage_irq_flag && !wr_flags) |=> low_voltage_irq_flag)
        else $error("source flag cleared by service");

    AST_ONLY_HALT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!asleep && !core_ev.halt) |=> !asleep)
        else $error("sleep without halt");

    AST_WDT_STOPS: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && !wdt_cfg[`SWL_CFG_WDT_SUB_BIT]) |-> !wdt_run)
        else $error("system-clocked watchdog runs asleep");

    AST_WDT_CLEAR_HALT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.halt && state == SWL_RUN) |-> wdt_clear)
        else $error("halt did not clear watchdog");

    AST_PDF_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (core_ev.clr_wdt && !(core_ev.halt && state == SWL_RUN)) |=> !power_down_flag)
        else $error("watchdog clear kept power-down");

    AST_TO_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wdt_wake && !ext_rst && !core_ev.halt) |=> watchdog_timeout_flag)
        else $error("time-out not flagged");

    AST_EXT_WAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && ext_rst) |=> state == SWL_RUN && !power_down_flag)
        else $error("external reset did not wake");

    AST_PORT_WAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && !ext_rst && pa_fall) |=> state == SWL_WAKE && !pc_sp_reset)
        else $error("port fall did not wake cleanly");

    // a full stack holds service off even with everything enabled
    AST_DEFER: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SWL_RUN && stack_full) |-> !irq_take)
        else $error("serviced with full stack");

    AST_SEL_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_low_voltage_detect_control |=> threshold_select == $past(reg_req.wdata[2:0]))
        else $error("threshold not written");

    AST_EN_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_low_voltage_detect_control |=> detector_enable == $past(reg_req.wdata[`SWL_LOW_VOLTAGE_DETECT_CONTROL_EN_BIT]))
        else $error("detector enable not written");

    AST_LV_WAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (asleep && !ext_rst && lvd_fire && !flags_at_halt[0]) |=> state == SWL_WAKE)
        else $error("low supply did not wake");
endmodule

`default_nettype wire

// ---- dv/swl_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// core model: issues instruction events one cycle long
module swl_core_model (
    input  wire logic             core_clk,   // system clock
    input  wire logic             sys_clk_en, // core clock gate
    input  wire logic             wdt_clear,  // watchdog clear pulse
    output swl_pkg::swl_core_ev_t core_ev,    // instruction events
    output logic                  stack_full  // no free stack level
);
    import swl_pkg::*;
    logic clr_seen;
    initial begin
        core_ev = '0;
        stack_full = 1'b0;
        clr_seen = 1'b0;
    end
    task automatic issue(input swl_core_ev_t ev);
        // a gated core executes nothing until woken
        while (sys_clk_en !== 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        core_ev <= ev;
        #1 clr_seen = wdt_clear;
        @(posedge core_clk);
        core_ev <= '0;
    endtask
endmodule
`default_nettype wire

// ---- dv/swl_sleep_ctrl_tb.sv ----
`include "swl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module swl_sleep_ctrl_tb;
    import swl_pkg::*;
    localparam int DLY = 4;
    logic core_clk = 0, reset_n = 0, ext_reset_n = 1, wdt_overflow = 0, lvd_comp = 0;
    logic [5:0] src_irq_set = '0;
    logic [7:0] port_a_pin = 8'hFF, reg_rdata, d;
    logic [2:0] threshold_select;
    logic detector_enable, sys_clk_en, wdt_run, wdt_clear, core_reset, pc_sp_reset, irq_take, gie, stack_full;
    logic woke, pcsp, crst;
    swl_reg_req_t reg_req = '0;
    swl_core_ev_t core_ev;
    int fails = 0, samples_checked = 0, cycles = 0;
    always #12.5 core_clk = ~core_clk;
    swl_sleep_ctrl #(.LVD_DELAY_CYC(DLY)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .core_ev(core_ev), .stack_full(stack_full), .src_irq_set(src_irq_set),
        .ext_reset_n(ext_reset_n), .port_a_pin(port_a_pin), .wdt_overflow(wdt_overflow), .lvd_comp(lvd_comp),
        .threshold_select(threshold_select), .detector_enable(detector_enable), .sys_clk_en(sys_clk_en),
        .wdt_run(wdt_run), .wdt_clear(wdt_clear), .core_reset(core_reset), .pc_sp_reset(pc_sp_reset),
        .irq_take(irq_take), .global_irq_enable(gie));
    swl_core_model core_u (.core_clk(core_clk), .sys_clk_en(sys_clk_en), .wdt_clear(wdt_clear),
        .core_ev(core_ev), .stack_full(stack_full));
    // ==========================================
    // checking and bus helpers
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_byte(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_req <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
        #1 v = reg_rdata;
    endtask
    task automatic pulse_src(input logic [5:0] m);
        @(posedge core_clk);
        src_irq_set <= m;
        @(posedge core_clk);
        src_irq_set <= '0;
    endtask
    // sleep wakes are seen as the clock gate reopening; reset pulses are collected meanwhile
    task automatic watch(input int n);
        woke = 0;
        pcsp = 0;
        crst = 0;
        repeat (n) begin
            tick(1);
            woke |= sys_clk_en;
            pcsp |= pc_sp_reset;
            crst |= core_reset;
        end
    endtask
    task automatic halt_chk();
        core_u.issue(swl_core_ev_t'{halt: 1'b1, default: '0});
        tick(1);
        chk_bit("clock gated", 1'b0, sys_clk_en);
        chk_bit("wdt clear at halt", 1'b1, core_u.clr_seen);
        reg_rd(`SWL_ADDR_STATUS, d);
        chk_byte("status asleep", 8'h05, d);
    endtask
    // ==========================================
    // scenarios
    task automatic t_low_voltage_detect_control();
        reg_rd(`SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL, d);
        chk_byte("low_voltage_detect_control reset", 8'h00, d);
        for (int c = 0; c < 8; c++) begin
            reg_wr(`SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL, 8'hF8 | 8'(c));
            reg_rd(`SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL, d);
            chk_byte("low_voltage_detect_control readback", 8'h10 | 8'(c), d);
            chk_byte("threshold", 8'(c), {5'h00, threshold_select});
            chk_bit("detector on", 1'b1, detector_enable);
        end
        reg_rd(4'hF, d);
        chk_byte("unmapped", 8'h00, d);
    endtask
    task automatic t_lvd();
        tick(8);
        halt_chk();
        lvd_comp <= 1'b1;
        watch(DLY + 14);
        chk_bit("low supply wake", 1'b1, woke);
        reg_rd(`SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL, d);
        chk_byte("output high", 8'h37, d);
        reg_rd(`SWL_ADDR_IRQ_FLAGS, d);
        chk_byte("lv flag", 8'h81, d);
        lvd_comp <= 1'b0;
        tick(4);
        reg_rd(`SWL_ADDR_LOW_VOLTAGE_DETECT_CONTROL, d);
        chk_byte("output low", 8'h17, d);
        reg_rd(`SWL_ADDR_IRQ_FLAGS, d);
        chk_byte("lv flag held", 8'h81, d);
        reg_wr(`SWL_ADDR_IRQ_FLAGS, 8'h00);
    endtask
    task automatic t_port();
        reg_wr(`SWL_ADDR_PORT_A_WAKE_ENABLE, 8'h01);
        halt_chk();
        port_a_pin <= 8'hFD;
        watch(10);
        chk_bit("disabled pin", 1'b0, woke);
        port_a_pin <= 8'hFC;
        watch(10);
        chk_bit("enabled pin", 1'b1, woke);
        chk_bit("no reset", 1'b0, pcsp | crst);
        port_a_pin <= 8'hFF;
    endtask
    task automatic t_irq();
        pulse_src(6'h01);
        halt_chk();
        pulse_src(6'h01);
        watch(10);
        chk_bit("flag already high", 1'b0, woke);
        pulse_src(6'h04);
        watch(10);
        chk_bit("irq wake", 1'b1, woke);
        chk_bit("deferred", 1'b0, irq_take);
        reg_rd(`SWL_ADDR_IRQ_FLAGS, d);
        chk_byte("flags held", 8'h05, d);
    endtask
    task automatic t_service();
        reg_wr(`SWL_ADDR_IRQ_EN, 8'h04);
        reg_wr(`SWL_ADDR_CONFIG, 8'h80);
        #1;
        chk_bit("take", 1'b1, irq_take);
        core_u.stack_full <= 1'b1;
        tick(1);
        chk_bit("stack full", 1'b0, irq_take);
        core_u.stack_full <= 1'b0;
        core_u.issue(swl_core_ev_t'{service_mf: 1'b1, service_grp: 3'h2, default: '0});
        reg_rd(`SWL_ADDR_IRQ_FLAGS, d);
        chk_byte("group cleared", 8'h01, d);
        reg_wr(`SWL_ADDR_CONFIG, 8'h00);
        core_u.issue(swl_core_ev_t'{ret_plain: 1'b1, default: '0});
        tick(1);
        chk_bit("plain return", 1'b0, gie);
        core_u.issue(swl_core_ev_t'{ret_enable: 1'b1, default: '0});
        tick(1);
        chk_bit("enable return", 1'b1, gie);
        reg_wr(`SWL_ADDR_IRQ_FLAGS, 8'h00);
    endtask
    task automatic t_wdt();
        reg_wr(`SWL_ADDR_CONFIG, 8'h03);
        halt_chk();
        chk_bit("sub clock runs", 1'b1, wdt_run);
        @(posedge core_clk) wdt_overflow <= 1'b1;
        watch(8);
        @(posedge core_clk) wdt_overflow <= 1'b0;
        chk_bit("wdt wake", 1'b1, woke & pcsp & ~crst);
        reg_rd(`SWL_ADDR_STATUS, d);
        chk_byte("time-out", 8'h03, d);
        core_u.issue(swl_core_ev_t'{clr_wdt: 1'b1, default: '0});
        reg_rd(`SWL_ADDR_STATUS, d);
        chk_bit("pdf cleared", 1'b0, d[0]);
        reg_wr(`SWL_ADDR_CONFIG, 8'h01);
        halt_chk();
        chk_bit("sys clock wdt stops", 1'b0, wdt_run);
        @(posedge core_clk) ext_reset_n <= 1'b0;
        watch(8);
        chk_bit("ext reset wake", 1'b1, woke & crst);
        @(posedge core_clk) ext_reset_n <= 1'b1;
        tick(4);
        reg_rd(`SWL_ADDR_STATUS, d);
        chk_byte("status after reset", 8'h00, d);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        tick(8);
        reset_n <= 1'b1;
        tick(2);
        t_low_voltage_detect_control();
        t_lvd();
        t_port();
        t_irq();
        t_service();
        t_wdt();
        tally_and_finish();
    end
endmodule
`default_nettype wire
